// >>> shared/adccfg_pkg.sv
// Package: register map, field layout, reset values and shared types of the converter control block
package adccfg_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'hE8;
  localparam logic [7:0] ADDR_ACCUMULATOR_CONFIG = 8'hB3;
  localparam logic [7:0] ADDR_CONVERTER_CONFIG = 8'hBC;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hBD;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBE;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_ACCUMULATOR_CONFIG = 8'h00;
  localparam logic [7:0] RESET_CONVERTER_CONFIG = 8'hF8;
  localparam logic [15:0] RESET_RESULT = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_BURST_BIT = 6;
  localparam int CTRL_DONE_BIT = 5;
  localparam int CFG_DIV_MSB = 7;
  localparam int CFG_DIV_LSB = 3;
  localparam int CFG_EIGHT_BIT = 2;
  localparam int CFG_TRACK_BIT = 1;
  localparam int CFG_GAIN_BIT = 0;
  localparam int ACC_TWELVE_BIT = 7;
  localparam int ACC_ACCUM_BIT = 6;
  localparam int ACC_SJ_MSB = 5;
  localparam int ACC_SJ_LSB = 3;
  localparam int ACC_RPT_MSB = 2;
  localparam int ACC_RPT_LSB = 0;

  // ----------------------------------------------------------------
  // Counts and codes
  // ----------------------------------------------------------------
  localparam logic [2:0] DELAY_SAR_CYCLES = 3'h4;
  localparam logic [2:0] TWELVE_BIT_PASSES = 3'h4;
  localparam logic [2:0] SJ_LEFT = 3'h4;
  localparam logic [3:0] LEFT_SHIFT_12 = 4'h4;
  localparam logic [3:0] LEFT_SHIFT_10 = 4'h6;
  localparam logic [3:0] LEFT_SHIFT_8 = 4'h8;

  typedef enum logic [1:0] {
    ADCCFG_RES_10 = 2'h0,
    ADCCFG_RES_8 = 2'h1,
    ADCCFG_RES_12 = 2'h2
  } adccfg_res_t;

  // Request bundle toward the analog core
  typedef struct packed {
    logic sar_tick;
    logic start;
    logic track;
    logic gain_one;
    adccfg_res_t resolution;
  } adccfg_core_req_t;

endpackage : adccfg_pkg

// >>> design/adccfg_top.sv
// Design: converter configuration, sequencing and result accumulation for a SAR converter
// Operation
// (RULE1) SAR clock is converter input clock divided by divider field plus one.
// (RULE2) Input clock is system clock without burst, fast oscillator with burst.
// (RULE3) Software sets divider for SAR clock nearest the allowed maximum.
// (RULE4) Eight-bit mode bit set gives 8-bit, clear gives 10 or 12 bit; code gives 12-bit if the twelve-bit bit is also set.
// (RULE5) Normal track mode starts conversion right after start event when enabled.
// (RULE6) Delayed track starts four SAR clocks after start event, tracking meanwhile.
// (RULE7) Gain bit clear selects gain one half, set selects gain one.
// (RULE8) Twelve-bit bit enables 12-bit conversions at one quarter throughput.
// (RULE9) Without burst, result holds latest conversion, or running sum when accumulating.
// (RULE10) Format codes 0-3 right justify with shift, code 4 left justifies.
// (RULE11) Burst repeat codes 0-5 perform 1, 4, 8, 16, 32, 64 conversions.
// (RULE12) In 12-bit mode repeat codes 1-5 perform 1, 2, 4, 8, 16.
// (RULE13) Software keeps repeat count at zero while burst is off.
// (RULE14) Burst enable bit turns burst operation on when set.
// (RULE15) Done flag sets per conversion, or per burst; software clears it.
// (RULE16) Accumulator clears at each new burst or accumulation sequence.
module adccfg_top #(
  parameter int DATA_WIDTH = 12,
  parameter int ACC_WIDTH = 18
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic sfr_write,
  input wire logic sfr_read,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic system_clock_source_tick,
  input wire logic hfosc_tick,
  input wire logic start_of_conversion,
  input wire logic core_done,
  input wire logic [DATA_WIDTH-1:0] core_data,
  output adccfg_pkg::adccfg_core_req_t core_req,
  output logic conversion_done_flag,
  output logic [15:0] result_word
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] control_reg;
  logic [7:0] accumulator_config_reg;
  logic [7:0] converter_config_reg;
  logic [15:0] result_reg;
  logic [7:0] rdata_reg;

  logic enable;
  logic burst_mode_enable;
  logic [4:0] sar_clock_divider;
  logic eight_bit_mode_enable;
  logic track_mode_select;
  logic gain_select;
  logic twelve_bit_mode_enable;
  logic accumulate_enable;
  logic [2:0] shift_justify_select;
  logic [2:0] repeat_count;

  assign enable = control_reg[adccfg_pkg::CTRL_ENABLE_BIT];
  assign burst_mode_enable = control_reg[adccfg_pkg::CTRL_BURST_BIT];
  assign sar_clock_divider = converter_config_reg[adccfg_pkg::CFG_DIV_MSB:adccfg_pkg::CFG_DIV_LSB];
  assign eight_bit_mode_enable = converter_config_reg[adccfg_pkg::CFG_EIGHT_BIT];
  assign track_mode_select = converter_config_reg[adccfg_pkg::CFG_TRACK_BIT];
  assign gain_select = converter_config_reg[adccfg_pkg::CFG_GAIN_BIT];
  assign twelve_bit_mode_enable = accumulator_config_reg[adccfg_pkg::ACC_TWELVE_BIT];
  assign accumulate_enable = accumulator_config_reg[adccfg_pkg::ACC_ACCUM_BIT];
  assign shift_justify_select = accumulator_config_reg[adccfg_pkg::ACC_SJ_MSB:adccfg_pkg::ACC_SJ_LSB];
  assign repeat_count = accumulator_config_reg[adccfg_pkg::ACC_RPT_MSB:adccfg_pkg::ACC_RPT_LSB];

  logic wr_control;
  logic wr_acc_cfg;
  logic result_event;
  logic done_set;

  assign wr_control = sfr_write && (sfr_addr == adccfg_pkg::ADDR_CONTROL);
  assign wr_acc_cfg = sfr_write && (sfr_addr == adccfg_pkg::ADDR_ACCUMULATOR_CONFIG);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      control_reg <= adccfg_pkg::RESET_CONTROL;
    end else begin
      if (wr_control) begin
        control_reg <= sfr_wdata;
      end
      if (done_set) begin
        control_reg[adccfg_pkg::CTRL_DONE_BIT] <= 1'b1; // RULE15
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      accumulator_config_reg <= adccfg_pkg::RESET_ACCUMULATOR_CONFIG;
      converter_config_reg <= adccfg_pkg::RESET_CONVERTER_CONFIG;
    end else begin
      if (wr_acc_cfg) begin
        accumulator_config_reg <= sfr_wdata;
      end
      if (sfr_write && (sfr_addr == adccfg_pkg::ADDR_CONVERTER_CONFIG)) begin
        converter_config_reg <= sfr_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Converter input clock and SAR clock divider
  // ----------------------------------------------------------------
  logic adc_clk_en;
  logic [4:0] div_count_reg;
  logic sar_tick_reg;

  assign adc_clk_en = burst_mode_enable ? hfosc_tick : system_clock_source_tick; // RULE2 RULE14

  always_ff @(posedge clock) begin
    if (srst) begin
      div_count_reg <= 5'h00;
      sar_tick_reg <= 1'b0;
    end else begin
      sar_tick_reg <= 1'b0;
      if (adc_clk_en) begin
        if (div_count_reg >= sar_clock_divider) begin
          div_count_reg <= 5'h00;
          sar_tick_reg <= 1'b1; // RULE1
        end else begin
          div_count_reg <= div_count_reg + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion count per start event
  // ----------------------------------------------------------------
  logic [6:0] burst_total;

  always_comb begin
    burst_total = 7'h01;
    if (burst_mode_enable) begin
      if (twelve_bit_mode_enable) begin
        burst_total = (repeat_count == 3'h0) ? 7'h01 : 7'(7'h01 << (repeat_count - 3'h1)); // RULE12
      end else begin
        burst_total = (repeat_count == 3'h0) ? 7'h01 : 7'(7'h01 << (repeat_count + 3'h1)); // RULE11
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ADCCFG_IDLE = 4'b0001,
    ADCCFG_DELAY = 4'b0010,
    ADCCFG_LAUNCH = 4'b0100,
    ADCCFG_CONVERT = 4'b1000
  } adccfg_state_t;

  adccfg_state_t state_reg;
  logic [2:0] delay_count_reg;
  logic [2:0] pass_count_reg;
  logic [6:0] conv_count_reg;
  logic start_reg;
  logic track_reg;
  logic [2:0] passes_needed;

  assign passes_needed = twelve_bit_mode_enable ? adccfg_pkg::TWELVE_BIT_PASSES : 3'h1;
  assign result_event = (state_reg == ADCCFG_CONVERT) && core_done && (pass_count_reg + 3'h1 >= passes_needed);
  assign done_set = result_event && (!burst_mode_enable || (conv_count_reg + 7'h01 >= burst_total)); // RULE15

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= ADCCFG_IDLE;
      delay_count_reg <= 3'h0;
      pass_count_reg <= 3'h0;
      conv_count_reg <= 7'h00;
      start_reg <= 1'b0;
      track_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      case (state_reg)
        ADCCFG_IDLE: begin
          conv_count_reg <= 7'h00;
          pass_count_reg <= 3'h0;
          delay_count_reg <= 3'h0;
          if (enable && start_of_conversion) begin
            if (track_mode_select) begin
              track_reg <= 1'b1; // RULE6
              state_reg <= ADCCFG_DELAY;
            end else begin
              state_reg <= ADCCFG_LAUNCH; // RULE5
            end
          end
        end
        ADCCFG_DELAY: begin
          if (sar_tick_reg) begin
            if (delay_count_reg == adccfg_pkg::DELAY_SAR_CYCLES - 3'h1) begin
              state_reg <= ADCCFG_LAUNCH; // RULE6
            end else begin
              delay_count_reg <= delay_count_reg + 3'h1;
            end
          end
        end
        ADCCFG_LAUNCH: begin
          if (sar_tick_reg) begin
            track_reg <= 1'b0;
            start_reg <= 1'b1;
            state_reg <= ADCCFG_CONVERT;
          end
        end
        ADCCFG_CONVERT: begin
          if (!enable) begin
            state_reg <= ADCCFG_IDLE;
          end else if (core_done) begin
            if (pass_count_reg + 3'h1 < passes_needed) begin
              pass_count_reg <= pass_count_reg + 3'h1; // RULE8
              state_reg <= ADCCFG_LAUNCH;
            end else if (done_set) begin
              state_reg <= ADCCFG_IDLE;
            end else begin
              pass_count_reg <= 3'h0;
              conv_count_reg <= conv_count_reg + 7'h01; // RULE11
              state_reg <= ADCCFG_LAUNCH;
            end
          end
        end
        default: begin
          state_reg <= ADCCFG_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  logic [ACC_WIDTH-1:0] acc_reg;
  logic fresh_seq_reg;
  logic [ACC_WIDTH-1:0] acc_next;
  logic first_of_burst;

  assign first_of_burst = burst_mode_enable && (conv_count_reg == 7'h00);

  always_comb begin
    if (first_of_burst || fresh_seq_reg || (!burst_mode_enable && !accumulate_enable)) begin
      acc_next = ACC_WIDTH'(core_data); // RULE16 RULE9
    end else begin
      acc_next = acc_reg + ACC_WIDTH'(core_data); // RULE9
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      acc_reg <= '0;
      fresh_seq_reg <= 1'b1;
    end else begin
      if (result_event) begin
        acc_reg <= acc_next;
        fresh_seq_reg <= 1'b0;
      end
      if (wr_acc_cfg) begin
        fresh_seq_reg <= 1'b1; // RULE16
      end
    end
  end

  // ----------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------
  logic [3:0] left_shift;

  always_comb begin
    if (twelve_bit_mode_enable) begin
      left_shift = adccfg_pkg::LEFT_SHIFT_12;
    end else if (eight_bit_mode_enable) begin
      left_shift = adccfg_pkg::LEFT_SHIFT_8;
    end else begin
      left_shift = adccfg_pkg::LEFT_SHIFT_10;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      result_reg <= adccfg_pkg::RESET_RESULT;
    end else if (shift_justify_select == adccfg_pkg::SJ_LEFT) begin
      result_reg <= 16'(acc_reg << left_shift); // RULE10
    end else if (shift_justify_select < adccfg_pkg::SJ_LEFT) begin
      result_reg <= 16'(acc_reg >> shift_justify_select[1:0]); // RULE10
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else if (sfr_read) begin
      case (sfr_addr)
        adccfg_pkg::ADDR_CONTROL: rdata_reg <= control_reg;
        adccfg_pkg::ADDR_ACCUMULATOR_CONFIG: rdata_reg <= accumulator_config_reg;
        adccfg_pkg::ADDR_CONVERTER_CONFIG: rdata_reg <= converter_config_reg;
        adccfg_pkg::ADDR_RESULT_LOW: rdata_reg <= result_reg[7:0];
        adccfg_pkg::ADDR_RESULT_HIGH: rdata_reg <= result_reg[15:8];
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core request and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      core_req <= '0;
    end else begin
      core_req.sar_tick <= sar_tick_reg;
      core_req.start <= start_reg;
      core_req.track <= track_reg;
      core_req.gain_one <= gain_select; // RULE7
      if (twelve_bit_mode_enable) begin
        core_req.resolution <= adccfg_pkg::ADCCFG_RES_12; // RULE8
      end else if (eight_bit_mode_enable) begin
        core_req.resolution <= adccfg_pkg::ADCCFG_RES_8; // RULE4
      end else begin
        core_req.resolution <= adccfg_pkg::ADCCFG_RES_10; // RULE4
      end
    end
  end

  assign sfr_rdata = rdata_reg;
  assign conversion_done_flag = control_reg[adccfg_pkg::CTRL_DONE_BIT];
  assign result_word = result_reg;

endmodule : adccfg_top

// >>> bench/adccfg_core_model.sv
// Partner: behavioural model of the analog converter core
module adccfg_core_model (
  input wire logic clock,
  input wire logic srst,
  input wire adccfg_pkg::adccfg_core_req_t core_req,
  input wire logic [11:0] sample,
  input wire logic [7:0] latency,
  output logic core_done,
  output logic [11:0] core_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_reg;
  logic [7:0] cnt_reg;
  // Data is only meaningful with core_done; otherwise it toggles every cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      busy_reg <= 1'b0;
      cnt_reg <= 8'h00;
      core_done <= 1'b0;
      core_data <= 12'h000;
    end else begin
      core_done <= 1'b0;
      core_data <= ~core_data;
      if (core_req.start) begin
        busy_reg <= 1'b1;
        cnt_reg <= latency;
      end else if (busy_reg && cnt_reg == 8'h00) begin
        busy_reg <= 1'b0;
        core_done <= 1'b1;
        core_data <= sample;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule : adccfg_core_model

// >>> bench/adccfg_monitor.sv
// Checker: port-level assertions of the converter control block
module adccfg_monitor (
  input wire logic clock,
  input wire logic srst,
  input wire logic sfr_write,
  input wire logic sfr_read,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic core_done,
  input wire adccfg_pkg::adccfg_core_req_t core_req,
  input wire logic conversion_done_flag,
  input wire logic [15:0] result_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cfg_reg;
  logic [7:0] acc_reg;
  logic [3:0] trk_cnt_reg;
  logic mapped;
  adccfg_pkg::adccfg_res_t res_exp;
  assign mapped = sfr_addr inside {8'hE8, 8'hB3, 8'hBC, 8'hBD, 8'hBE};
  assign res_exp = acc_reg[7] ? adccfg_pkg::ADCCFG_RES_12 :
    (cfg_reg[2] ? adccfg_pkg::ADCCFG_RES_8 : adccfg_pkg::ADCCFG_RES_10);
  // Shadow copies of the configuration registers
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_reg <= 8'hF8;
      acc_reg <= 8'h00;
    end else if (sfr_write && sfr_addr == 8'hBC) begin
      cfg_reg <= sfr_wdata;
    end else if (sfr_write && sfr_addr == 8'hB3) begin
      acc_reg <= sfr_wdata;
    end
  end
  // SAR ticks seen while tracking
  always_ff @(posedge clock) begin
    if (srst || !core_req.track) begin
      trk_cnt_reg <= 4'h0;
    end else if (core_req.sar_tick && trk_cnt_reg != 4'hF) begin
      trk_cnt_reg <= trk_cnt_reg + 4'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_cfg_write;
    sfr_write && sfr_addr == 8'hBC;
  endsequence
  sequence s_flag_clear;
    sfr_write && sfr_addr == 8'hE8 && !sfr_wdata[5] && !core_done;
  endsequence
  a_gain_follows: assert property (s_cfg_write |-> ##2 core_req.gain_one == $past(sfr_wdata[0], 2))
    else $error("gain select not applied");
  a_res_follows: assert property (!$past(cfg_reg[2] && acc_reg[7])
    |-> core_req.resolution == $past(res_exp))
    else $error("resolution does not match configuration");
  a_delay_ticks: assert property (core_req.start && $past(core_req.track)
    |-> trk_cnt_reg >= {1'b0, adccfg_pkg::DELAY_SAR_CYCLES})
    else $error("delayed start came too early");
  a_flag_cause: assert property ($rose(conversion_done_flag) |-> $past(core_done))
    else $error("done flag set without a finished pass");
  a_flag_clear: assert property (s_flag_clear |=> !conversion_done_flag)
    else $error("done flag not cleared by write");
  a_result_cause: assert property ($changed(result_word) |-> $past(core_done, 2) || $past(sfr_write)
    || $past(sfr_write, 2) || $past(sfr_write, 3))
    else $error("result changed without cause");
  a_unmapped_zero: assert property (sfr_read && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_result_read: assert property (sfr_read && sfr_addr == 8'hBE |=> sfr_rdata == $past(result_word[15:8]))
    else $error("result high byte read mismatch");
  c_flag_seen: cover property ($rose(conversion_done_flag));
endmodule : adccfg_monitor

bind adccfg_top adccfg_monitor adccfg_monitor_inst (.clock(clock), .srst(srst), .sfr_write(sfr_write),
  .sfr_read(sfr_read), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .core_done(core_done),
  .core_req(core_req), .conversion_done_flag(conversion_done_flag), .result_word(result_word));

// >>> bench/tb_adccfg_top.sv
// Testbench: register-level scenarios for the converter control block
module tb_adccfg_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, srst, sfr_write, sfr_read, sys_tick, hf_tick, soc, core_done, flag;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, lat, ctl;
  logic [11:0] sample, core_data;
  logic [15:0] result_word;
  adccfg_pkg::adccfg_core_req_t core_req;
  int failures, comparisons, cycles, n, gap, k, m, trk;
  adccfg_top adccfg_top_inst (.clock(clock), .srst(srst), .sfr_write(sfr_write), .sfr_read(sfr_read),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .system_clock_source_tick(sys_tick),
    .hfosc_tick(hf_tick), .start_of_conversion(soc), .core_done(core_done), .core_data(core_data),
    .core_req(core_req), .conversion_done_flag(flag), .result_word(result_word));
  adccfg_core_model adccfg_core_model_inst (.clock(clock), .srst(srst), .core_req(core_req), .sample(sample),
    .latency(lat), .core_done(core_done), .core_data(core_data));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task end_of_test();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      failures++;
      $display("FAIL %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_cnt
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    sfr_write = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge clock);
    #1;
    sfr_write = 1'b0;
  endtask : wr
  task rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    #1;
    sfr_read = 1'b1;
    sfr_addr = a;
    @(posedge clock);
    #1;
    sfr_read = 1'b0;
    @(posedge clock);
    #1;
    chk_val({8'h00, sfr_rdata}, {8'h00, e});
  endtask : rdc
  // Start one conversion, count passes until the flag, then clear it
  task conv();
    int i;
    n = 0;
    @(posedge clock);
    #1;
    soc = 1'b1;
    @(posedge clock);
    #1;
    soc = 1'b0;
    for (i = 0; i < 3000 && flag !== 1'b1; i++) begin
      @(posedge clock);
      #1;
      if (core_done === 1'b1) n++;
    end
    @(posedge clock);
    @(posedge clock);
    #1;
    chk_val({15'h0000, flag}, 16'h0001);
    wr(8'hE8, ctl);
    @(posedge clock);
    #1;
    chk_val({15'h0000, flag}, 16'h0000);
  endtask : conv
  // Wait for tracking, count SAR ticks while it lasts and time the first two
  task meas();
    int i;
    int last;
    for (i = 0; i < 200 && core_req.track !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    trk = 0;
    gap = 0;
    last = 0;
    for (i = 0; i < 200 && core_req.track === 1'b1; i++) begin
      if (core_req.sar_tick === 1'b1) begin
        if (trk == 1) gap = i - last;
        last = i;
        trk++;
      end
      @(posedge clock);
      #1;
    end
  endtask : meas
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    {sfr_write, sfr_read, soc, hf_tick} = 4'h0;
    sys_tick = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sample = 12'h000;
    lat = 8'h02;
    ctl = 8'h80;
    repeat (4) @(posedge clock);
    #1;
    srst = 1'b0;
    rdc(8'hE8, 8'h00);
    rdc(8'hB3, 8'h00);
    rdc(8'hBC, 8'hF8);
    rdc(8'hBE, 8'h00);
    wr(8'h55, 8'hFF);
    rdc(8'h55, 8'h00);
    wr(8'hBC, 8'h09);
    rdc(8'hBC, 8'h09);
    chk_val({15'h0000, core_req.gain_one}, 16'h0001);
    wr(8'hE8, ctl);
    sample = 12'h123;
    conv();
    chk_val(result_word, 16'h0123);
    wr(8'hBD, 8'hFF);
    rdc(8'hBD, 8'h23);
    rdc(8'hBE, 8'h01);
    wr(8'hB3, 8'h40);
    sample = 12'h100;
    lat = 8'h14;
    conv();
    conv();
    chk_val(result_word, 16'h0200);
    lat = 8'h02;
    wr(8'hB3, 8'h40);
    conv();
    chk_val(result_word, 16'h0100);
    sample = 12'h3F8;
    for (k = 0; k < 4; k++) begin
      wr(8'hB3, 8'(k << 3));
      conv();
      chk_val(result_word, 16'h03F8 >> k);
    end
    wr(8'hB3, 8'h20);
    conv();
    chk_val(result_word, 16'hFE00);
    wr(8'hB3, 8'h28);
    sample = 12'h001;
    conv();
    chk_val(result_word, 16'hFE00);
    wr(8'hBC, 8'h0C);
    wr(8'hB3, 8'h20);
    sample = 12'h0AB;
    conv();
    chk_val(result_word, 16'hAB00);
    chk_val({14'h0000, core_req.resolution}, 16'h0001);
    wr(8'hBC, 8'h08);
    wr(8'hB3, 8'h80);
    sample = 12'hABC;
    conv();
    chk_cnt(n, 4);
    chk_val(result_word, 16'h0ABC);
    wr(8'hB3, 8'h00);
    wr(8'hBC, 8'h12);
    fork
      conv();
      meas();
    join
    chk_cnt(gap, 3);
    chk_cnt(n, 1);
    // Delay ticks plus the tick that launches the pass
    chk_cnt(trk, adccfg_pkg::DELAY_SAR_CYCLES + 1);
    sys_tick = 1'b0;
    hf_tick = 1'b1;
    wr(8'hBC, 8'h08);
    ctl = 8'hC0;
    wr(8'hE8, ctl);
    sample = 12'h005;
    for (k = 0; k < 6; k++) begin
      m = (k == 0) ? 1 : 2 << k;
      wr(8'hB3, 8'(k));
      conv();
      chk_cnt(n, m);
      chk_val(result_word, 16'(5 * m));
    end
    for (k = 1; k < 6; k++) begin
      wr(8'hB3, 8'h80 | 8'(k));
      conv();
      chk_cnt(n, 2 << k);
    end
    end_of_test();
  end
endmodule : tb_adccfg_top
